/* File: logic/irq_regs.svh */
// timing counts, field positions and codes of the interrupt front end
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

`define IRQ_CLK_MHZ        100
`define IRQ_REQ_N          4
`define IRQ_VEC_W          8
`define IRQ_PRIO_LSB       3
`define IRQ_PRIO_W         5
`define IRQ_CNT_W          8
`define IRQ_RUN_W          16
`define IRQ_SYNC_HOLD      2
`define IRQ_RECOG_CYC      4
`define IRQ_STOP_MIN_CYC   1
`define IRQ_STOP_SIMPLE_CYC 2
`define IRQ_RESP_CYC       6
`define IRQ_BASE_CYC       85
`define IRQ_RET_CYC        78
`define IRQ_RET_PEND_CYC   157
`define IRQ_TWO_CYC        157
`define IRQ_POST_NOM_CYC   60
`define IRQ_FCACHE_CYC     24
`define IRQ_EXTCTL_CYC     18
`define IRQ_NESTED_CYC     14
`define IRQ_ICMISS_CYC     5
`define IRQ_RESUME_THR     16'h0208
`define IRQ_RET_CODE_W     3
`define IRQ_RET_INTR       3'h7

`endif

/* File: logic/irq_pkg.sv */
// types shared by the interrupt front end
package irq_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_STOP,
    S_ENTRY,
    S_POST,
    S_RET,
    S_RPEND
  } irq_state_t;
endpackage : irq_pkg

/* File: logic/irq_pin_qual.sv */
// two-stage synchroniser and inactive-then-active qualifier for one request pin
`timescale 1ns/1ns
module irq_pin_qual #(
  parameter int HOLD = 2
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // pin and event
  input  wire logic pinIn,
  output logic      reqEvent
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

  if (HOLD < 1) begin : g_bad
    $error("irq_pin_qual: HOLD must be at least one");
  end

  logic          sync1_ff;
  logic          sync2_ff;
  logic [CW-1:0] lowCnt_ff;
  logic [CW-1:0] highCnt_ff;
  logic          armed_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
    end
  end

  // qualification counts on the synchronised level only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lowCnt_ff  <= '0;
      highCnt_ff <= '0;
    end else if (sync2_ff) begin
      lowCnt_ff  <= '0;
      highCnt_ff <= (highCnt_ff == HOLD_C) ? highCnt_ff : highCnt_ff + CW'(1);
    end else begin
      highCnt_ff <= '0;
      lowCnt_ff  <= (lowCnt_ff == HOLD_C) ? lowCnt_ff : lowCnt_ff + CW'(1);
    end
  end

  // a held level fires once; re-arm needs a fresh inactive spell
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      armed_ff <= 1'b0;
      reqEvent <= 1'b0;
    end else begin
      reqEvent <= 1'b0;
      if (!sync2_ff && lowCnt_ff + CW'(1) >= HOLD_C) begin
        armed_ff <= 1'b1;
      end else if (sync2_ff && armed_ff && highCnt_ff + CW'(1) >= HOLD_C) begin
        armed_ff <= 1'b0;
        reqEvent <= 1'b1;
      end
    end
  end
endmodule : irq_pin_qual

/* File: logic/irq_prio_pick.sv */
// fixed-priority pick, lowest index wins
`timescale 1ns/1ns
module irq_prio_pick #(
  parameter int N = 4
) (
  // request vector
  input  wire logic [N-1:0]         req,
  // winner
  output logic      [N-1:0]         winOh,
  output logic      [$clog2(N)-1:0] winIdx,
  output logic                      anyReq
);
  logic [N:0] blocked;

  if (N < 2) begin : g_bad
    $error("irq_prio_pick: N must be at least two");
  end

  assign blocked[0] = 1'b0;
  for (genvar i = 0; i < N; i++) begin : g_pick
    assign winOh[i]     = req[i] & ~blocked[i];
    assign blocked[i+1] = blocked[i] | req[i];
  end
  assign anyReq = blocked[N];

  always_comb begin
    winIdx = '0;
    for (int j = N - 1; j >= 0; j--) begin
      if (req[j]) begin
        winIdx = j[$clog2(N)-1:0];
      end
    end
  end
endmodule : irq_prio_pick

/* File: logic/irq_capture_and_latency.sv */
// interrupt capture register, recognition and entry/return cycle sequencer
`timescale 1ns/1ns
`include "irq_regs.svh"

// Overview of operation
// - every request pin is synchronised independently
// - four-bit capture register, one bit per pin
// - capture keeps latching while recognition disabled
// - accept only at boundaries or simple start; then disable recognition
// - sampling clears capture; lowest set bit picks vector
// - leftover sampled bits ORed back into capture
// - input zero highest priority, three lowest
// - highest-priority arrival captured by end of entry posted before recognition re-enabled
// - recognition four cycles, stop one or two
// - pin to entry start in six clocks
// - base request to handler latency 85 cycles
// - return 78; with pending or second 157
// - pending check on return, priority drop, message
// - posting compares priority, strobes vector to table
// - long-running instruction gets resumption record
// - register frame cache miss adds 24
// - external controller adds 18; nested adds 14
// - handler instruction cache miss adds five
// - self message handled internally, no bus
// - three-bit return code selects interrupt return
// - vector from per-pin byte of control word
module irq_capture_and_latency #(
  parameter int REQ_N   = `IRQ_REQ_N,
  parameter int HOLD    = `IRQ_SYNC_HOLD,
  parameter int CLK_MHZ = `IRQ_CLK_MHZ
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  // request pins, active high at this boundary
  input  wire logic [REQ_N-1:0]             reqPin,
  // per-pin vector bytes
  input  wire logic [REQ_N*`IRQ_VEC_W-1:0]  vecCtl,
  // execution context
  input  wire logic                         instrBoundary,
  input  wire logic                         simpleStart,
  input  wire logic [`IRQ_RUN_W-1:0]        instrRunCycles,
  input  wire logic [`IRQ_PRIO_W-1:0]       curPriority,
  input  wire logic                         frameCacheMiss,
  input  wire logic                         extCtlMode,
  input  wire logic                         icacheMiss,
  // return and pending triggers
  input  wire logic                         retReq,
  input  wire logic [`IRQ_RET_CODE_W-1:0]   retCode,
  input  wire logic                         modifyProcessControlsLower,
  input  wire logic                         interagentMessageSelf,
  input  wire logic                         pendingExists,
  // status and sequencing
  output logic [REQ_N-1:0]                  capture,
  output logic                              recogEnabled,
  output logic                              entryStart,
  output logic                              handlerStart,
  output logic [`IRQ_VEC_W-1:0]             vectorOut,
  output logic                              resumeSave,
  output logic                              inIntState,
  output logic                              retDone,
  output logic                              pendCheck,
  // posting to the interrupt table
  output logic                              postStrobe,
  output logic [`IRQ_VEC_W-1:0]             postVector,
  output logic                              postBelowCur
);
  localparam int IW = $clog2(REQ_N);
  localparam int CW = `IRQ_CNT_W;
  // cycles between entry start and handler start
  localparam logic [CW-1:0] ENTRY_C  = CW'(`IRQ_BASE_CYC - `IRQ_RESP_CYC);
  localparam logic [CW-1:0] POST_C   = CW'(`IRQ_TWO_CYC - `IRQ_BASE_CYC);
  localparam logic [CW-1:0] RET_C    = CW'(`IRQ_RET_CYC);
  localparam logic [CW-1:0] RPEND_C  = CW'(`IRQ_RET_PEND_CYC - `IRQ_RET_CYC);
  localparam logic [CW-1:0] FCACHE_C = CW'(`IRQ_FCACHE_CYC);
  localparam logic [CW-1:0] EXTCTL_C = CW'(`IRQ_EXTCTL_CYC);
  localparam logic [CW-1:0] NEST_C   = CW'(`IRQ_NESTED_CYC);
  localparam logic [CW-1:0] ICMISS_C = CW'(`IRQ_ICMISS_CYC);
  localparam logic [CW-1:0] STOPS_C  = CW'(`IRQ_STOP_SIMPLE_CYC);
  localparam logic [CW-1:0] STOPM_C  = CW'(`IRQ_STOP_MIN_CYC);
  localparam int LONGEST = `IRQ_BASE_CYC - `IRQ_RESP_CYC + `IRQ_FCACHE_CYC +
                           `IRQ_EXTCTL_CYC + `IRQ_NESTED_CYC + `IRQ_ICMISS_CYC;

  if (REQ_N != `IRQ_REQ_N) begin : g_bad_n
    $error("irq_capture_and_latency: exactly four request pins supported");
  end
  if (HOLD < 1 || HOLD > `IRQ_SYNC_HOLD) begin : g_bad_hold
    $error("irq_capture_and_latency: HOLD must be one or two");
  end
  if (CLK_MHZ < 1) begin : g_bad_clk
    $error("irq_capture_and_latency: CLK_MHZ must be positive");
  end
  // priority field must sit inside a vector byte
  if (`IRQ_PRIO_LSB + `IRQ_PRIO_W > `IRQ_VEC_W) begin : g_bad_prio
    $error("irq_capture_and_latency: priority field outside vector byte");
  end
  // a stop phase lasts a cycle at least, simple start no shorter
  if (`IRQ_STOP_MIN_CYC < 1 || `IRQ_STOP_SIMPLE_CYC < `IRQ_STOP_MIN_CYC) begin : g_bad_stop
    $error("irq_capture_and_latency: bad stop phase lengths");
  end
  // extended spans must outlast the spans they extend
  if (`IRQ_BASE_CYC <= `IRQ_RESP_CYC || `IRQ_TWO_CYC <= `IRQ_BASE_CYC ||
      `IRQ_RET_PEND_CYC <= `IRQ_RET_CYC) begin : g_bad_span
    $error("irq_capture_and_latency: extended spans must exceed base spans");
  end
  // padded posting must cover the nominal posting work
  if (`IRQ_TWO_CYC - `IRQ_BASE_CYC < `IRQ_POST_NOM_CYC) begin : g_bad_post
    $error("irq_capture_and_latency: posting span shorter than nominal");
  end
  // the entry span with all extras, and the return span, must fit the down-counter
  if (LONGEST >= (1 << CW) || `IRQ_RET_CYC >= (1 << CW)) begin : g_bad_cnt
    $error("irq_capture_and_latency: span counter too narrow");
  end
  // resume threshold must stay below the run counter's ceiling
  if (`IRQ_RESUME_THR >= (1 << `IRQ_RUN_W) - 1) begin : g_bad_thr
    $error("irq_capture_and_latency: resume threshold out of range");
  end

  irq_pkg::irq_state_t state_ff;
  irq_pkg::irq_state_t nxt_state;

  logic [REQ_N-1:0] newEvent;
  logic [REQ_N-1:0] winOh;
  logic [IW-1:0]    winIdx;
  logic             anyCap;
  logic [CW-1:0]    cnt_ff;
  logic [CW-1:0]    nxt_cnt;
  logic             sampleNow;
  logic             accept;
  logic             cntZero;
  logic             pendTrig;
  logic [CW-1:0]    entryExtra;
  logic [`IRQ_VEC_W-1:0] winVec;

  // one qualifier per pin, each on its own
  for (genvar i = 0; i < REQ_N; i++) begin : g_pin
    irq_pin_qual #(
      .HOLD (HOLD)
    ) u_qual (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .pinIn    (reqPin[i]),
      .reqEvent (newEvent[i])
    );
  end

  irq_prio_pick #(
    .N (REQ_N)
  ) u_pick (
    .req    (capture),
    .winOh  (winOh),
    .winIdx (winIdx),
    .anyReq (anyCap)
  );

  assign winVec  = vecCtl[winIdx*`IRQ_VEC_W +: `IRQ_VEC_W];
  assign cntZero = (cnt_ff == '0);

  // recognition: captured bit at a boundary with recognition on
  assign accept = (state_ff == irq_pkg::S_IDLE) && recogEnabled && anyCap &&
                  (instrBoundary || simpleStart);

  // a second sample happens at the end of entry when more are waiting
  assign sampleNow = accept ||
                     ((state_ff == irq_pkg::S_ENTRY) && cntZero && anyCap);

  // self messages stay on chip: a plain level, no bus cycle behind it
  assign pendTrig = (state_ff == irq_pkg::S_IDLE) && !accept &&
                    (modifyProcessControlsLower || interagentMessageSelf);

  // special-case additions to the entry span
  always_comb begin
    entryExtra = '0;
    if (frameCacheMiss) begin
      entryExtra = entryExtra + FCACHE_C;
    end
    if (extCtlMode) begin
      entryExtra = entryExtra + EXTCTL_C;
    end
    if (inIntState) begin
      entryExtra = entryExtra + NEST_C;
    end
    if (icacheMiss) begin
      entryExtra = entryExtra + ICMISS_C;
    end
  end

  // capture register: new arrivals always win, sample clears the winner only
  // a pin event landing in the sampling cycle must never be lost
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      capture <= '0;
    end else if (sampleNow) begin
      capture <= newEvent | (capture & ~winOh);
    end else begin
      capture <= capture | newEvent;
    end
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cntZero ? cnt_ff : cnt_ff - CW'(1);
    unique case (state_ff)
      irq_pkg::S_IDLE: begin
        if (accept) begin
          nxt_state = irq_pkg::S_STOP;
          nxt_cnt   = (simpleStart ? STOPS_C : STOPM_C) - CW'(1);
        end else if (pendTrig && pendingExists) begin
          nxt_state = irq_pkg::S_ENTRY;
          nxt_cnt   = ENTRY_C + entryExtra - CW'(1);
        end else if (retReq && retCode == `IRQ_RET_INTR) begin
          nxt_state = irq_pkg::S_RET;
          nxt_cnt   = RET_C - CW'(1);
        end
      end
      irq_pkg::S_STOP: begin
        if (cntZero) begin
          nxt_state = irq_pkg::S_ENTRY;
          nxt_cnt   = ENTRY_C + entryExtra - CW'(1);
        end
      end
      irq_pkg::S_ENTRY: begin
        if (cntZero) begin
          nxt_state = anyCap ? irq_pkg::S_POST : irq_pkg::S_IDLE;
          nxt_cnt   = POST_C - CW'(1);
        end
      end
      irq_pkg::S_POST: begin
        if (cntZero) begin
          nxt_state = irq_pkg::S_IDLE;
        end
      end
      irq_pkg::S_RET: begin
        if (cntZero) begin
          nxt_state = pendingExists ? irq_pkg::S_RPEND : irq_pkg::S_IDLE;
          nxt_cnt   = RPEND_C - CW'(1);
        end
      end
      irq_pkg::S_RPEND: begin
        if (cntZero) begin
          nxt_state = irq_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= irq_pkg::S_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // recognition enable: off on accept, back on once the handler is called
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      recogEnabled <= 1'b1;
    end else if (accept) begin
      recogEnabled <= 1'b0;
    end else if (handlerStart) begin
      recogEnabled <= 1'b1;
    end
  end

  // vector held from the accepted sample
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      vectorOut <= '0;
    end else if (accept) begin
      vectorOut <= winVec;
    end
  end

  // resumption record for instructions that ran long
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      resumeSave <= 1'b0;
    end else if (accept) begin
      resumeSave <= (instrRunCycles > `IRQ_RESUME_THR);
    end
  end

  // entry and handler strobes; one cycle late so both come from flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      entryStart   <= 1'b0;
      handlerStart <= 1'b0;
    end else begin
      entryStart   <= (state_ff == irq_pkg::S_STOP) && cntZero;
      handlerStart <= ((state_ff == irq_pkg::S_ENTRY) && cntZero && !anyCap) ||
                      ((state_ff == irq_pkg::S_POST) && cntZero);
    end
  end

  // interrupted-state flag
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      inIntState <= 1'b0;
    end else if (handlerStart) begin
      inIntState <= 1'b1;
    end else if (retDone) begin
      inIntState <= 1'b0;
    end
  end

  // return completion and pending checks
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      retDone   <= 1'b0;
      pendCheck <= 1'b0;
    end else begin
      retDone   <= ((state_ff == irq_pkg::S_RET) && cntZero && !pendingExists) ||
                   ((state_ff == irq_pkg::S_RPEND) && cntZero);
      pendCheck <= ((state_ff == irq_pkg::S_RET) && cntZero) || pendTrig;
    end
  end

  // posting the second request to the table
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      postStrobe   <= 1'b0;
      postVector   <= '0;
      postBelowCur <= 1'b0;
    end else begin
      postStrobe <= 1'b0;
      if ((state_ff == irq_pkg::S_ENTRY) && cntZero && anyCap) begin
        postStrobe   <= 1'b1;
        postVector   <= winVec;
        postBelowCur <= (winVec[`IRQ_PRIO_LSB +: `IRQ_PRIO_W] <= curPriority);
      end
    end
  end
endmodule : irq_capture_and_latency

/* File: tb/irq_src_model.sv */
// request source model driving the four request pins
`timescale 1ns/1ns
module irq_src_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // per-pin fire command and pins
  input  wire logic [3:0] fire,
  output logic      [3:0] reqPin
);
  logic [2:0] cnt_ff [4];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rstn) cnt_ff[i] <= 3'h0;
      else if (fire[i]) cnt_ff[i] <= 3'h5;
      else if (cnt_ff[i] != 3'h0) cnt_ff[i] <= cnt_ff[i] - 3'h1;
    end
  end

  // two cycles low, then three high, each pin on its own
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      reqPin[i] = (cnt_ff[i] != 3'h0) && (cnt_ff[i] <= 3'h3);
    end
  end
endmodule : irq_src_model

/* File: tb/irq_chk_assertions.sv */
// concurrent checks on the interrupt front end ports
`timescale 1ns/1ns
`include "irq_regs.svh"
module irq_chk_assertions #(
  parameter int REQ_N = 4
) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  // context
  input wire logic [`IRQ_RUN_W-1:0]   instrRunCycles,
  input wire logic [`IRQ_PRIO_W-1:0]  curPriority,
  // status
  input wire logic [REQ_N-1:0]        capture,
  input wire logic                    recogEnabled,
  input wire logic                    entryStart,
  input wire logic                    handlerStart,
  input wire logic                    resumeSave,
  input wire logic                    inIntState,
  input wire logic                    retDone,
  input wire logic                    postStrobe,
  input wire logic [`IRQ_VEC_W-1:0]   postVector,
  input wire logic                    postBelowCur
);
  localparam int SPAN_MIN = 79;
  localparam int SPAN_MAX = 240;
  logic [REQ_N-1:0] prevCap_ff;
  logic [REQ_N-1:0] gone;
  logic [REQ_N-1:0] lowBit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  always_ff @(posedge ref_clk) prevCap_ff <= capture;
  assign gone   = prevCap_ff & ~capture;
  assign lowBit = prevCap_ff & (~prevCap_ff + 1'b1);

  property p_entry_pulse; entryStart |=> !entryStart; endproperty
  a_entry_pulse: assert property (p_entry_pulse) else $error("entry pulse too long");
  property p_entry_locks; entryStart |-> !recogEnabled; endproperty
  a_entry_locks: assert property (p_entry_locks) else $error("recognition left on");
  property p_entry_span; entryStart |-> ##[SPAN_MIN:SPAN_MAX] handlerStart; endproperty
  a_entry_span: assert property (p_entry_span) else $error("handler start late");
  property p_post_pulse; postStrobe |=> !postStrobe; endproperty
  a_post_pulse: assert property (p_post_pulse) else $error("post pulse too long");
  property p_post_prio;
    postStrobe |-> postBelowCur == (postVector[`IRQ_PRIO_LSB +: `IRQ_PRIO_W] <= curPriority);
  endproperty
  a_post_prio: assert property (p_post_prio) else $error("post priority flag wrong");
  property p_resume;
    entryStart |-> resumeSave == (instrRunCycles > `IRQ_RESUME_THR);
  endproperty
  a_resume: assert property (p_resume) else $error("resume flag wrong");
  property p_leave_int; $fell(inIntState) |-> $past(retDone); endproperty
  a_leave_int: assert property (p_leave_int) else $error("left interrupt state early");
  property p_clear_low; gone != '0 |-> gone == lowBit; endproperty
  a_clear_low: assert property (p_clear_low) else $error("wrong capture bit cleared");
  property p_clear_off; gone != '0 |-> !recogEnabled; endproperty
  a_clear_off: assert property (p_clear_off) else $error("capture cleared while enabled");
endmodule : irq_chk_assertions

bind irq_capture_and_latency irq_chk_assertions #(.REQ_N(REQ_N)) chk_u (
  .ref_clk, .rstn, .instrRunCycles, .curPriority, .capture, .recogEnabled,
  .entryStart, .handlerStart, .resumeSave, .inIntState, .retDone,
  .postStrobe, .postVector, .postBelowCur
);

/* File: tb/tb_irq_capture_and_latency.sv */
// self-checking bench of the interrupt front end
`timescale 1ns/1ns
`define CHK(nm, e, a) begin nTests++; if ((a) !== (e)) begin errCount++; \
  $display("Error %s exp %0h got %0h", nm, e, a); end end
module tb_irq_capture_and_latency;
  logic        ref_clk, rstn, instrBoundary, simpleStart, frameCacheMiss;
  logic        extCtlMode, icacheMiss, retReq, modifyProcessControlsLower;
  logic        interagentMessageSelf, pendingExists, recogEnabled, entryStart;
  logic        handlerStart, resumeSave, inIntState, retDone, pendCheck;
  logic        postStrobe, postBelowCur;
  logic [3:0]  fire, reqPin, capture;
  logic [31:0] vecCtl;
  logic [15:0] instrRunCycles;
  logic [4:0]  curPriority;
  logic [2:0]  retCode;
  logic [7:0]  vectorOut, postVector, lastPost;
  int          errCount, nTests;

  irq_src_model src_u (.ref_clk, .rstn, .fire, .reqPin);
  irq_capture_and_latency dut_u (
    .ref_clk, .rstn, .reqPin, .vecCtl, .instrBoundary, .simpleStart, .instrRunCycles,
    .curPriority, .frameCacheMiss, .extCtlMode, .icacheMiss, .retReq, .retCode,
    .modifyProcessControlsLower, .interagentMessageSelf, .pendingExists, .capture,
    .recogEnabled, .entryStart, .handlerStart, .vectorOut, .resumeSave, .inIntState,
    .retDone, .pendCheck, .postStrobe, .postVector, .postBelowCur
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // waits for entry, handler, return or pend check pulse; records any posted vector
  task automatic waitFor(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (postStrobe === 1'b1) lastPost = postVector;
    end while ((sel == 0 ? entryStart : sel == 1 ? handlerStart : sel == 2 ? retDone :
                pendCheck) !== 1'b1 && n < lim);
    if (n >= lim) begin
      errCount++;
      $display("Error wait %0d exp pulse got none", sel);
      conclude();
    end
  endtask : waitFor

  task automatic doReset;
    @(posedge ref_clk) rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : doReset

  task automatic entry(input logic [3:0] m, input int i, input int span);
    int n;
    @(posedge ref_clk) fire <= m;
    @(posedge ref_clk) fire <= 4'h0;
    waitFor(0, 40, n);
    `CHK("vector", vecCtl[8*i +: 8], vectorOut)
    waitFor(1, 400, n);
    `CHK("entry span", span, n)
  endtask : entry

  task automatic doRet(input logic [2:0] code, input int cyc);
    int n;
    @(posedge ref_clk) retReq <= 1'b1;
    retCode <= code;
    @(posedge ref_clk) retReq <= 1'b0;
    waitFor(2, 300, n);
    `CHK("return span", 1'b1, (n >= cyc - 1 && n <= cyc + 2))
  endtask : doRet

  task automatic tReset;
    doReset();
    `CHK("recog", 1'b1, recogEnabled)
    `CHK("capture", 4'h0, capture)
    $display("done reset");
  endtask : tReset

  task automatic tPins;
    for (int i = 0; i < 4; i++) begin
      doReset();
      entry(4'h1 << i, i, 79);
      @(posedge ref_clk);
      #1;
      `CHK("in int", 1'b1, inIntState)
      doRet(3'h7, 78);
      @(posedge ref_clk);
      #1;
      `CHK("left int", 1'b0, inIntState)
    end
    $display("done pins");
  endtask : tPins

  task automatic tSimul;
    doReset();
    entry(4'hF, 0, 151);
    `CHK("posted vector", vecCtl[15:8], lastPost)
    `CHK("leftover capture", 4'hC, capture)
    $display("done simultaneous");
  endtask : tSimul

  task automatic tMasked;
    int n;
    for (int k = 0; k < 2; k++) begin
      doReset();
      @(posedge ref_clk) instrBoundary <= 1'b0;
      fire <= 4'h2;
      @(posedge ref_clk) fire <= 4'h0;
      repeat (20) @(posedge ref_clk);
      `CHK("held capture", 4'h2, capture)
      if (k == 0) instrBoundary <= 1'b1;
      else simpleStart <= 1'b1;
      waitFor(0, 10, n);
      `CHK("late vector", vecCtl[15:8], vectorOut)
      `CHK("stop cycles", 2 + k, n)
    end
    @(posedge ref_clk) simpleStart <= 1'b0;
    instrBoundary <= 1'b1;
    $display("done masked");
  endtask : tMasked

  task automatic tExtras;
    doReset();
    @(posedge ref_clk) instrRunCycles <= 16'h0209;
    frameCacheMiss <= 1'b1;
    entry(4'h8, 3, 103);
    `CHK("resume", 1'b1, resumeSave)
    doRet(3'h7, 78);
    @(posedge ref_clk) instrRunCycles <= 16'h0208;
    {frameCacheMiss, extCtlMode, icacheMiss} <= 3'h3;
    entry(4'h1, 0, 102);
    `CHK("no resume", 1'b0, resumeSave)
    @(posedge ref_clk) {extCtlMode, icacheMiss} <= 2'h0;
    entry(4'h2, 1, 93);
    $display("done extras");
  endtask : tExtras

  task automatic tPend;
    int n;
    doReset();
    entry(4'h4, 2, 79);
    @(posedge ref_clk) pendingExists <= 1'b1;
    doRet(3'h7, 157);
    @(posedge ref_clk) pendingExists <= 1'b0;
    retReq <= 1'b1;
    retCode <= 3'h1;
    @(posedge ref_clk) retReq <= 1'b0;
    n = 0;
    repeat (200) begin
      @(posedge ref_clk);
      #1;
      if (pendCheck === 1'b1 || retDone === 1'b1) n++;
    end
    `CHK("bad code ignored", 0, n)
    @(posedge ref_clk) modifyProcessControlsLower <= 1'b1;
    @(posedge ref_clk) modifyProcessControlsLower <= 1'b0;
    #1;
    `CHK("pend check lower", 1'b1, pendCheck)
    @(posedge ref_clk) interagentMessageSelf <= 1'b1;
    pendingExists <= 1'b1;
    @(posedge ref_clk) interagentMessageSelf <= 1'b0;
    pendingExists <= 1'b0;
    #1;
    `CHK("pend check message", 1'b1, pendCheck)
    waitFor(1, 100, n);
    `CHK("pending entry span", 79, n)
    $display("done pending");
  endtask : tPend

  initial begin
    {rstn, simpleStart, frameCacheMiss, extCtlMode, icacheMiss, retReq} = 6'h00;
    {modifyProcessControlsLower, interagentMessageSelf, pendingExists} = 3'h0;
    instrBoundary = 1'b1;
    fire = 4'h0;
    vecCtl = 32'h4C3A_2818;
    instrRunCycles = 16'h0000;
    curPriority = 5'h04;
    retCode = 3'h0;
    lastPost = 8'h00;
    errCount = 0;
    nTests = 0;
    tReset();
    tPins();
    tSimul();
    tMasked();
    tExtras();
    tPend();
    conclude();
  end
endmodule : tb_irq_capture_and_latency
